/* hw/ocpa_pkg.sv */
// Purpose: Shared constants and types for the compare and accumulator block
// Assumes: Wishbone byte addresses, one 32-bit word per register
// Notes:   Upper data bits of every register read as zero
package ocpa_pkg;

   localparam int NCH         = 8;
   localparam int CNT_W       = 16;
   localparam int ADR_W       = 6;
   localparam int DAT_W       = 32;
   localparam int SEL_W       = 4;
   localparam int LANE_W      = 8;
   localparam int ACT_W       = 2;
   localparam int SYNC_STAGES = 2;
   localparam int CH7         = 7;

   ////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [ADR_W-1:0] OFS_CTRL   = 6'h00;
   localparam logic [ADR_W-1:0] OFS_CHSEL  = 6'h04;
   localparam logic [ADR_W-1:0] OFS_PINDIS = 6'h08;
   localparam logic [ADR_W-1:0] OFS_OUTCTL = 6'h0C;
   localparam logic [ADR_W-1:0] OFS_FORCE  = 6'h10;
   localparam logic [ADR_W-1:0] OFS_FLAG   = 6'h14;
   localparam logic [ADR_W-1:0] OFS_IRQEN  = 6'h18;
   localparam logic [ADR_W-1:0] OFS_MASK7  = 6'h1C;
   localparam logic [ADR_W-1:0] OFS_DATA7  = 6'h20;
   localparam logic [ADR_W-1:0] OFS_ACCCTL = 6'h24;
   localparam logic [ADR_W-1:0] OFS_ACCFLG = 6'h28;
   localparam logic [ADR_W-1:0] OFS_ACCCNT = 6'h2C;
   localparam logic [ADR_W-1:0] OFS_PORT   = 6'h30;

   ////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int CTRL_W       = 4;
   localparam int CTRL_RUN     = 0;
   localparam int CTRL_FFC     = 1;
   localparam int CTRL_COUNTER_RESET_ON_MATCH    = 2;
   localparam int CTRL_OVERFLOW_TOGGLE_SELECT    = 3;
   localparam int ACCF_IN      = 0;
   localparam int ACCF_OV      = 1;
   localparam int PORT_DIR_LSB = 8;

   localparam logic [CNT_W-1:0] ACC_MAX = 16'hFFFF;
   localparam logic [CNT_W-1:0] ACC_ONE = 16'h0001;

   typedef enum logic [ACT_W-1:0] {
      PIN_KEEP   = 2'h0,
      PIN_TOGGLE = 2'h1,
      PIN_LOW    = 2'h2,
      PIN_HIGH   = 2'h3
   } pin_act_t;

   typedef struct packed {
      logic     disconnect;
      pin_act_t act;
      logic     maskBit;
      logic     dataBit;
   } ch_ctl_t;

   typedef struct packed {
      logic inIrqEn;
      logic ovIrqEn;
      logic edgeHigh;
      logic gated;
      logic enable;
   } acc_ctl_t;

endpackage

/* hw/sync_edge.sv */
// Purpose: Synchroniser with edge detection for the accumulator input
// Assumes: Pulses last longer than the synchroniser depth
// Notes:   Edges held off until prev holds a real pin sample
module sync_edge #(
   parameter int STAGES = ocpa_pkg::SYNC_STAGES
) (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic ce,
   input  wire logic d,
   output logic      level,
   output logic      rise,
   output logic      fall
);

   logic [STAGES-1:0] chain;
   logic              prev;
   logic [STAGES:0]   armed;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         chain <= '0;
         prev  <= '0;
         armed <= '0;
      end else if (ce) begin
         chain <= {chain[STAGES-2:0], d}; // RQ14
         prev  <= chain[STAGES-1];
         // Reset zeros are no pin sample, so a pin idling high gives no false rise
         armed <= {armed[STAGES-1:0], 1'b1};
      end
   end

   assign level = chain[STAGES-1];
   assign rise  = armed[STAGES] & level & ~prev;
   assign fall  = armed[STAGES] & ~level & prev;

endmodule

/* hw/oc_channel.sv */
// Purpose: Internal pin register of one compare channel
// Assumes: Match and force already qualified by the caller
// Notes:   Channel 7 override beats the channel's own action
module oc_channel (
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic              ce,
   input  wire ocpa_pkg::ch_ctl_t ctl,
   input  wire logic              match,
   input  wire logic              forceAct,
   input  wire logic              ch7Event,
   output logic                   pinLevel
);

   logic next_pinLevel;

   always_comb begin
      next_pinLevel = pinLevel;
      if (ch7Event && ctl.maskBit) begin
         next_pinLevel = ctl.dataBit; // RQ8 RQ9
      end else if (forceAct || (match && !ctl.disconnect)) begin // RQ2 RQ7 RQ12
         unique case (ctl.act)
            ocpa_pkg::PIN_KEEP:   next_pinLevel = pinLevel; // RQ5
            ocpa_pkg::PIN_TOGGLE: next_pinLevel = ~pinLevel; // RQ6
            ocpa_pkg::PIN_LOW:    next_pinLevel = '0; // RQ6
            ocpa_pkg::PIN_HIGH:   next_pinLevel = '1; // RQ6
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pinLevel <= '0;
      end else if (ce) begin
         pinLevel <= next_pinLevel;
      end
   end

   a_keep_no_action: assert property (@(posedge clk) disable iff (!arst_n) // RQ5
      ce && !ch7Event && ctl.act == ocpa_pkg::PIN_KEEP |=> $stable(pinLevel))
      else $error("pin moved with no action selected");

   a_disconnect_hold: assert property (@(posedge clk) disable iff (!arst_n) // RQ2
      ce && !ch7Event && !forceAct && ctl.disconnect |=> $stable(pinLevel))
      else $error("match moved a disconnected pin");

endmodule

/* hw/oc_pulse_accumulator.sv */
// Purpose: Output compare pin logic and 16-bit pulse accumulator
// Assumes: Counter, compare values and prescaler tap come from the timer
// Notes:   Wishbone classic slave, ack one cycle after the request

// Behaviour
// RQ1: Channel select bit set makes that channel an output compare channel.
// RQ2: Counter equal to compare value sets, clears or toggles pin unless disconnected.
// RQ3: Each compare match sets the channel flag; enable gates its interrupt.
// RQ4: Flag clears by writing one while timer or accumulator is enabled.
// RQ5: Mode and level both zero means no pin action on match.
// RQ6: Codes 01 toggle, 10 drive low, 11 drive high.
// RQ7: Force bit performs the pin action at once without setting the flag.
// RQ8: Channel 7 event has priority over other channels' compare actions.
// RQ9: Channel 7 event drives masked pins to channel 7 data levels.
// RQ10: With reset enable, channel 7 match resets the counter, even as accumulator.
// RQ11: Port writes to compare-owned pins are latched, shown once pin is free.
// RQ12: Force with select, disconnect and timer set preloads the pin register.
// RQ13: A 16-bit accumulator counts events or gated time by mode bit.
// RQ14: Outside source holds accumulator input pulses over two clock periods.
// RQ15: Event mode counts active channel 7 pin edges, edge bit picks polarity.
// RQ16: Software frees channel 7 pin by clearing its mode, level, mask bit.
// RQ17: Rollover from all ones sets overflow flag; enable gates its interrupt.
// RQ18: Event counting continues while the timer enable is clear.
// RQ19: Gated mode counts divide-by-64 ticks while pin holds active level.
// RQ20: Gated mode trailing edge sets input flag; enable gates its interrupt.
// RQ21: Divide-by-64 ticks stop while the timer is inactive.
// RQ22: Active-high requests for eight channels, input, overflow and timer overflow.
// RQ23: Accumulator flags clear by one-write when enabled, or by fast-clear access.
module oc_pulse_accumulator #(
   parameter int NCH   = ocpa_pkg::NCH,
   parameter int CNT_W = ocpa_pkg::CNT_W
) (
   input  wire logic                            clk,
   input  wire logic                            arst_n,
   input  wire logic                            ce,
   input  wire logic                            wb_cyc_i,
   input  wire logic                            wb_stb_i,
   input  wire logic                            wb_we_i,
   input  wire logic [ocpa_pkg::ADR_W-1:0]      wb_adr_i,
   input  wire logic [ocpa_pkg::SEL_W-1:0]      wb_sel_i,
   input  wire logic [ocpa_pkg::DAT_W-1:0]      wb_dat_i,
   output logic      [ocpa_pkg::DAT_W-1:0]      wb_dat_o,
   output logic                                 wb_ack_o,
   input  wire logic [CNT_W-1:0]                count,
   input  wire logic [NCH-1:0][CNT_W-1:0]       compareVal,
   input  wire logic                            counterOverflow,
   input  wire logic                            div64Tick,
   input  wire logic                            timerOverflowFlag,
   input  wire logic [NCH-1:0]                  pinIn,
   output logic      [NCH-1:0]                  pinOut,
   output logic      [NCH-1:0]                  pinOe,
   output logic      [NCH-1:0]                  channelCompareSelect,
   output logic                                 timerRunEnable,
   output logic                                 counterReset,
   output logic      [NCH-1:0]                  channelIrq,
   output logic                                 accInputIrq,
   output logic                                 accOverflowIrq,
   output logic                                 timerOverflowIrq
);

   ////////////////////////////////////////////////////////////////////////
   // Register state
   logic [ocpa_pkg::CTRL_W-1:0] ctrl;
   logic [NCH-1:0]              chSel;
   logic [NCH-1:0]              pinDis;
   logic [2*NCH-1:0]            outCtl;
   logic [NCH-1:0]              chIrqEn;
   logic [NCH-1:0]              mask7;
   logic [NCH-1:0]              data7;
   logic [NCH-1:0]              portData;
   logic [NCH-1:0]              portDir;
   ocpa_pkg::acc_ctl_t          acc;
   logic [NCH-1:0]              chFlag;
   logic                        accInFlag;
   logic                        accOvFlag;
   logic [CNT_W-1:0]            accCount;
   logic [CNT_W-1:0]            prevCount;

   ////////////////////////////////////////////////////////////////////////
   // Bus decode
   logic                       wbReq;
   logic                       wbWr;
   logic [ocpa_pkg::DAT_W-1:0] regVal;
   logic [2*ocpa_pkg::LANE_W-1:0] laneMask;
   logic [2*ocpa_pkg::LANE_W-1:0] wrVal;
   logic [2*ocpa_pkg::LANE_W-1:0] w1c;
   logic                       timerEn;
   logic                       clrOk;
   logic                       fastClr;
   logic                       accWr;

   assign wbReq    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wbWr     = wbReq & wb_we_i;
   assign laneMask = {{ocpa_pkg::LANE_W{wb_sel_i[1]}}, {ocpa_pkg::LANE_W{wb_sel_i[0]}}};
   assign wrVal    = (regVal[2*ocpa_pkg::LANE_W-1:0] & ~laneMask) | (wb_dat_i[2*ocpa_pkg::LANE_W-1:0] & laneMask);
   assign w1c      = wb_dat_i[2*ocpa_pkg::LANE_W-1:0] & laneMask;
   assign timerEn  = ctrl[ocpa_pkg::CTRL_RUN];
   assign clrOk    = timerEn | acc.enable; // RQ4 RQ23
   assign accWr    = wbWr && wb_adr_i == ocpa_pkg::OFS_ACCCNT;
   // Any access, read or write, counts for fast clear
   assign fastClr  = wbReq && wb_adr_i == ocpa_pkg::OFS_ACCCNT && ctrl[ocpa_pkg::CTRL_FFC]; // RQ23

   always_comb begin
      regVal = '0;
      unique case (wb_adr_i)
         ocpa_pkg::OFS_CTRL:   regVal[ocpa_pkg::CTRL_W-1:0] = ctrl;
         ocpa_pkg::OFS_CHSEL:  regVal[NCH-1:0] = chSel;
         ocpa_pkg::OFS_PINDIS: regVal[NCH-1:0] = pinDis;
         ocpa_pkg::OFS_OUTCTL: regVal[2*NCH-1:0] = outCtl;
         ocpa_pkg::OFS_FLAG:   regVal[NCH-1:0] = chFlag;
         ocpa_pkg::OFS_IRQEN:  regVal[NCH-1:0] = chIrqEn;
         ocpa_pkg::OFS_MASK7:  regVal[NCH-1:0] = mask7;
         ocpa_pkg::OFS_DATA7:  regVal[NCH-1:0] = data7;
         ocpa_pkg::OFS_ACCCTL: regVal[$bits(ocpa_pkg::acc_ctl_t)-1:0] = acc;
         ocpa_pkg::OFS_ACCFLG: begin
            regVal[ocpa_pkg::ACCF_IN] = accInFlag;
            regVal[ocpa_pkg::ACCF_OV] = accOvFlag;
         end
         ocpa_pkg::OFS_ACCCNT: regVal[CNT_W-1:0] = accCount;
         ocpa_pkg::OFS_PORT: begin
            regVal[NCH-1:0] = portData;
            regVal[ocpa_pkg::PORT_DIR_LSB +: NCH] = portDir;
         end
         default:              regVal = '0;
      endcase
   end

   // Unmapped addresses still ack, reading zero and ignoring writes
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wb_ack_o <= '0;
         wb_dat_o <= '0;
      end else if (ce) begin
         wb_ack_o <= wbReq;
         if (wbReq) begin
            wb_dat_o <= regVal;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl     <= '0;
         chSel    <= '0;
         pinDis   <= '0;
         outCtl   <= '0;
         chIrqEn  <= '0;
         mask7    <= '0;
         data7    <= '0;
         acc      <= '0;
         portData <= '0;
         portDir  <= '0;
      end else if (ce && wbWr) begin
         unique case (wb_adr_i)
            ocpa_pkg::OFS_CTRL:   ctrl <= wrVal[ocpa_pkg::CTRL_W-1:0];
            ocpa_pkg::OFS_CHSEL:  chSel <= wrVal[NCH-1:0]; // RQ1
            ocpa_pkg::OFS_PINDIS: pinDis <= wrVal[NCH-1:0];
            ocpa_pkg::OFS_OUTCTL: outCtl <= wrVal[2*NCH-1:0];
            ocpa_pkg::OFS_IRQEN:  chIrqEn <= wrVal[NCH-1:0];
            ocpa_pkg::OFS_MASK7:  mask7 <= wrVal[NCH-1:0];
            ocpa_pkg::OFS_DATA7:  data7 <= wrVal[NCH-1:0];
            ocpa_pkg::OFS_ACCCTL: acc <= wrVal[$bits(ocpa_pkg::acc_ctl_t)-1:0];
            ocpa_pkg::OFS_PORT: begin
               portData <= wrVal[NCH-1:0]; // RQ11
               portDir  <= wrVal[ocpa_pkg::PORT_DIR_LSB +: NCH];
            end
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Compare matches
   logic [NCH-1:0] match;
   logic [NCH-1:0] forceHit;
   logic [NCH-1:0] ownPin;
   logic [NCH-1:0] pinReg;
   logic           cntMoved;
   logic           ch7Event;

   // A counter parked by the prescaler must match only once
   assign cntMoved = count != prevCount;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prevCount <= '0;
      end else if (ce) begin
         prevCount <= count;
      end
   end

   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         match[i] = timerEn && chSel[i] && cntMoved && count == compareVal[i]; // RQ1 RQ2
      end
   end

   assign forceHit = (wbWr && wb_adr_i == ocpa_pkg::OFS_FORCE) ?
                     (wrVal[NCH-1:0] & chSel & {NCH{timerEn}}) : '0; // RQ7 RQ12
   assign ch7Event = match[ocpa_pkg::CH7] ||
                     (counterOverflow && timerEn && ctrl[ocpa_pkg::CTRL_OVERFLOW_TOGGLE_SELECT]); // RQ8

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         counterReset <= '0;
      end else if (ce) begin
         counterReset <= match[ocpa_pkg::CH7] && ctrl[ocpa_pkg::CTRL_COUNTER_RESET_ON_MATCH]; // RQ10
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-channel pin registers
   for (genvar g = 0; g < NCH; g++) begin : gen_ch
      ocpa_pkg::ch_ctl_t chCtl;
      assign chCtl.disconnect = pinDis[g];
      assign chCtl.act        = ocpa_pkg::pin_act_t'(outCtl[ocpa_pkg::ACT_W*g +: ocpa_pkg::ACT_W]);
      assign chCtl.maskBit    = mask7[g];
      assign chCtl.dataBit    = data7[g];
      // Timer owns the pin only once connected, so a preload never glitches
      assign ownPin[g] = chSel[g] && !pinDis[g] &&
                         (chCtl.act != ocpa_pkg::PIN_KEEP || mask7[g]); // RQ11 RQ12 RQ16

      oc_channel u_ch (
         .clk      (clk),
         .arst_n   (arst_n),
         .ce       (ce),
         .ctl      (chCtl),
         .match    (match[g]),
         .forceAct (forceHit[g]),
         .ch7Event (ch7Event),
         .pinLevel (pinReg[g])
      );
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pinOut <= '0;
         pinOe  <= '0;
      end else if (ce) begin
         pinOut <= (ownPin & pinReg) | (~ownPin & portData); // RQ11
         pinOe  <= ownPin | portDir;
      end
   end

   assign channelCompareSelect = chSel;
   assign timerRunEnable       = timerEn;

   ////////////////////////////////////////////////////////////////////////
   // Channel flags; a set in the clearing cycle wins
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         chFlag <= '0;
      end else if (ce) begin
         if (wbWr && wb_adr_i == ocpa_pkg::OFS_FLAG && clrOk) begin
            chFlag <= (chFlag & ~w1c[NCH-1:0]) | match; // RQ3 RQ4
         end else begin
            chFlag <= chFlag | match; // RQ3
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pulse accumulator
   logic inLevel;
   logic inRise;
   logic inFall;
   logic activeEdge;
   logic activeLevel;
   logic trailEdge;
   logic evInc;
   logic gtInc;
   logic accInc;
   logic ovEvt;
   logic inEvt;

   sync_edge u_sync (
      .clk    (clk),
      .arst_n (arst_n),
      .ce     (ce),
      .d      (pinIn[ocpa_pkg::CH7]),
      .level  (inLevel),
      .rise   (inRise),
      .fall   (inFall)
   );

   assign activeEdge  = acc.edgeHigh ? inRise : inFall; // RQ15
   assign activeLevel = acc.edgeHigh ? inLevel : ~inLevel; // RQ19
   assign trailEdge   = acc.edgeHigh ? inFall : inRise; // RQ20
   // Event mode ignores the timer enable
   assign evInc  = acc.enable && !acc.gated && activeEdge; // RQ15 RQ18
   // No prescaler tap while the timer is stopped
   assign gtInc  = acc.enable && acc.gated && timerEn && div64Tick && activeLevel; // RQ19 RQ21
   assign accInc = evInc || gtInc; // RQ13
   assign ovEvt  = accInc && !accWr && accCount == ocpa_pkg::ACC_MAX; // RQ17
   assign inEvt  = evInc || (acc.enable && acc.gated && trailEdge); // RQ20

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         accCount <= '0;
      end else if (ce) begin
         if (accWr) begin
            accCount <= wrVal[CNT_W-1:0];
         end else if (accInc) begin
            accCount <= accCount + ocpa_pkg::ACC_ONE; // RQ13
         end
      end
   end

   logic flgWr;
   assign flgWr = wbWr && wb_adr_i == ocpa_pkg::OFS_ACCFLG && clrOk;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         accInFlag <= '0;
         accOvFlag <= '0;
      end else if (ce) begin
         accInFlag <= (accInFlag && !(flgWr && w1c[ocpa_pkg::ACCF_IN]) && !fastClr) || inEvt; // RQ20 RQ23
         accOvFlag <= (accOvFlag && !(flgWr && w1c[ocpa_pkg::ACCF_OV]) && !fastClr) || ovEvt; // RQ17 RQ23
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt requests
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         channelIrq       <= '0;
         accInputIrq      <= '0;
         accOverflowIrq   <= '0;
         timerOverflowIrq <= '0;
      end else if (ce) begin
         channelIrq       <= chFlag & chIrqEn; // RQ3 RQ22
         accInputIrq      <= accInFlag && acc.inIrqEn; // RQ20 RQ22
         accOverflowIrq   <= accOvFlag && acc.ovIrqEn; // RQ17 RQ22
         timerOverflowIrq <= timerOverflowFlag; // RQ22
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_flag_on_match: assert property (@(posedge clk) disable iff (!arst_n) // RQ3
      ce && |match |=> (chFlag & $past(match)) == $past(match))
      else $error("match did not set its flag");

   a_irq_follows_flag: assert property (@(posedge clk) disable iff (!arst_n) // RQ3
      ce |=> channelIrq == $past(chFlag & chIrqEn))
      else $error("channel request not gated by enable");

   a_clear_needs_enable: assert property (@(posedge clk) disable iff (!arst_n) // RQ4
      ce && !clrOk |=> (chFlag & $past(chFlag)) == $past(chFlag))
      else $error("flag cleared while both enables low");

   a_ch7_override: assert property (@(posedge clk) disable iff (!arst_n) // RQ9
      ce && ch7Event |=> ((pinReg ^ $past(data7)) & $past(mask7)) == '0)
      else $error("masked pins did not take channel 7 data");

   a_counter_reset: assert property (@(posedge clk) disable iff (!arst_n) // RQ10
      ce && match[ocpa_pkg::CH7] && ctrl[ocpa_pkg::CTRL_COUNTER_RESET_ON_MATCH] |=> counterReset)
      else $error("channel 7 match did not reset counter");

   a_acc_rollover: assert property (@(posedge clk) disable iff (!arst_n) // RQ17
      ce && ovEvt |=> accOvFlag && accCount == '0)
      else $error("rollover did not set overflow flag");

   a_event_count: assert property (@(posedge clk) disable iff (!arst_n) // RQ15
      ce && evInc && !accWr |=> accCount == CNT_W'($past(accCount) + ocpa_pkg::ACC_ONE))
      else $error("event edge not counted");

   a_gated_halt: assert property (@(posedge clk) disable iff (!arst_n) // RQ21
      ce && acc.gated && !timerEn && !accWr |=> $stable(accCount))
      else $error("gated count moved with timer stopped");

endmodule

/* bench/pin_timer_model.sv */
// Purpose: Timer counter, prescaler tap and channel pin wires
// Assumes: Counter steps each clock while the timer runs
// Notes:   Pins not driven by the block follow the bench's levels
module pin_timer_model (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        run,
   input  wire logic        counterReset,
   input  wire logic [7:0]  pinOut,
   input  wire logic [7:0]  pinOe,
   input  wire logic [7:0]  ext,
   output logic      [15:0] count,
   output logic             counterOverflow,
   output logic             div64Tick,
   output logic      [7:0]  pinIn
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [5:0] pre;
   assign pinIn = (pinOe & pinOut) | (~pinOe & ext);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count           <= 16'h0000;
         pre             <= 6'h00;
         counterOverflow <= 1'b0;
         div64Tick       <= 1'b0;
      end else begin
         // Idle timer gives no divided tick
         div64Tick       <= run && pre == 6'h3F;
         counterOverflow <= run && count == 16'hFFFF;
         if (run)
            pre <= pre + 6'h01;
         if (counterReset)
            count <= 16'h0000;
         else if (run)
            count <= count + 16'h0001;
      end
   end
endmodule

/* bench/tb_top.sv */
// Purpose: Self-checking bench for the compare and accumulator block
// Assumes: Ack answers within a few cycles
// Notes:   Random pulse counts and compare offsets from a fixed seed
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, arst_n, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, timerOverflowFlag;
   logic [5:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [15:0] count;
   logic [7:0][15:0] compareVal;
   logic counterOverflow, div64Tick, timerRunEnable, counterReset, accInputIrq, accOverflowIrq, timerOverflowIrq;
   logic [7:0] pinIn, pinOut, pinOe, channelCompareSelect, channelIrq, ext;
   int seed, mismatches, n_checks, n, off, i;
   always #20 clk = ~clk;
   oc_pulse_accumulator u_oc_pulse_accumulator (.clk, .arst_n, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .count, .compareVal, .counterOverflow, .div64Tick,
      .timerOverflowFlag, .pinIn, .pinOut, .pinOe, .channelCompareSelect, .timerRunEnable, .counterReset,
      .channelIrq, .accInputIrq, .accOverflowIrq, .timerOverflowIrq);
   pin_timer_model u_pin_timer_model (.clk, .arst_n, .run(timerRunEnable), .counterReset, .pinOut, .pinOe,
      .ext, .count, .counterOverflow, .div64Tick, .pinIn);
   ////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
      int i;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      // Bounded wait for the slave's answer
      for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++)
         @(posedge clk);
      if (i == 20) begin
         mismatches++;
         end_of_test();
      end
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] r;
      wb(1'b1, a, d, r);
   endtask
   task automatic rdc(input logic [5:0] a, input logic [31:0] e);
      logic [31:0] r;
      wb(1'b0, a, 32'h00000000, r);
      check_val(r, e);
   endtask
   task automatic pulse(input int k);
      repeat (k) begin
         ext[7] <= 1'b1;
         repeat (4) @(posedge clk);
         ext[7] <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask
   task automatic hold_high(input int k);
      ext[7] <= 1'b1;
      repeat (k) @(posedge clk);
      ext[7] <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      seed = 60431;
      {arst_n, wb_cyc_i, wb_stb_i, wb_we_i, timerOverflowFlag} = 5'h00;
      {ce, wb_sel_i, wb_adr_i, wb_dat_i, ext} = {1'b1, 4'hF, 6'h00, 32'h00000000, 8'h00};
      compareVal = {8{16'hFFFF}};
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      rdc(ocpa_pkg::OFS_CTRL, 32'h00000000);
      rdc(6'h3C, 32'h00000000);
      $display("test reset done");
      wr(ocpa_pkg::OFS_IRQEN, 32'h00000001);
      wr(ocpa_pkg::OFS_CHSEL, 32'h00000003);
      wr(ocpa_pkg::OFS_OUTCTL, 32'h0000000D);
      wr(ocpa_pkg::OFS_CTRL, 32'h00000001);
      off = 30 + ($random(seed) & 15);
      compareVal[0] <= count + off[15:0];
      repeat (off + 6) @(posedge clk);
      check_val({31'h0, pinOut[0]}, 32'h00000001);
      check_val({31'h0, channelIrq[0]}, 32'h00000001);
      check_val({24'h0, pinOe}, 32'h00000003);
      check_val({31'h0, timerRunEnable}, 32'h00000001);
      rdc(ocpa_pkg::OFS_FLAG, 32'h00000001);
      wr(ocpa_pkg::OFS_FORCE, 32'h00000002);
      repeat (3) @(posedge clk);
      check_val({31'h0, pinOut[1]}, 32'h00000001);
      rdc(ocpa_pkg::OFS_FLAG, 32'h00000001);
      wr(ocpa_pkg::OFS_FLAG, 32'h00000001);
      rdc(ocpa_pkg::OFS_FLAG, 32'h00000000);
      $display("test compare done");
      wr(ocpa_pkg::OFS_CTRL, 32'h00000000);
      wr(ocpa_pkg::OFS_ACCCTL, 32'h0000000D);
      n = 1 + ($random(seed) & 7);
      pulse(n);
      rdc(ocpa_pkg::OFS_ACCCNT, 32'(n));
      wr(ocpa_pkg::OFS_ACCCNT, 32'h0000FFFF);
      pulse(1);
      rdc(ocpa_pkg::OFS_ACCFLG, 32'h00000003);
      check_val({31'h0, accOverflowIrq}, 32'h00000001);
      wr(ocpa_pkg::OFS_CTRL, 32'h00000002);
      rdc(ocpa_pkg::OFS_ACCCNT, 32'h00000000);
      rdc(ocpa_pkg::OFS_ACCFLG, 32'h00000000);
      timerOverflowFlag <= 1'b1;
      repeat (3) @(posedge clk);
      check_val({31'h0, timerOverflowIrq}, 32'h00000001);
      wr(ocpa_pkg::OFS_ACCCNT, 32'h00000000);
      wr(ocpa_pkg::OFS_ACCCTL, 32'h00000017);
      wr(ocpa_pkg::OFS_CTRL, 32'h00000001);
      n = 1 + ($random(seed) & 3);
      hold_high(64 * n);
      check_val({31'h0, accInputIrq}, 32'h00000001);
      rdc(ocpa_pkg::OFS_ACCCNT, 32'(n));
      wr(ocpa_pkg::OFS_CTRL, 32'h00000000);
      hold_high(128);
      rdc(ocpa_pkg::OFS_ACCCNT, 32'(n));
      $display("test accumulator done");
      wr(ocpa_pkg::OFS_MASK7, 32'h00000001);
      wr(ocpa_pkg::OFS_CHSEL, 32'h00000083);
      wr(ocpa_pkg::OFS_CTRL, 32'h00000005);
      compareVal[7] <= count + 16'h0010;
      for (i = 0; i < 100 && counterReset !== 1'b1; i++)
         @(posedge clk);
      check_val({31'h0, counterReset}, 32'h00000001);
      if (counterReset !== 1'b1)
         end_of_test();
      repeat (2) @(posedge clk);
      check_val({31'h0, pinOut[0]}, 32'h00000000);
      rdc(ocpa_pkg::OFS_FLAG, 32'h00000080);
      wr(ocpa_pkg::OFS_PORT, 32'h00000001);
      repeat (2) @(posedge clk);
      check_val({31'h0, pinOut[0]}, 32'h00000000);
      wr(ocpa_pkg::OFS_PINDIS, 32'h00000001);
      repeat (2) @(posedge clk);
      check_val({31'h0, pinOut[0]}, 32'h00000001);
      $display("test channel 7 done");
      end_of_test();
   end
endmodule
